// [src/branch_compare_skip_unit.sv]
// Compare, skip and conditional branch unit with an APB register window
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module branch_compare_skip_unit (
    // Clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    // APB slave
    input  wire logic [7:0]                       paddr,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [31:0]                      pwdata,
    output var  logic [31:0]                      prdata,
    output var  logic                             pready,
    output var  logic                             pslverr,
    // Core state
    output var  logic [15:0]                      pc_out,
    output var  branch_compare_pkg::status_type   flags_out,
    output var  logic                             busy,
    output var  logic                             done
);

    branch_compare_pkg::op_word_type op_q;
    branch_compare_pkg::operand_type operand_q;
    branch_compare_pkg::status_type  flags_q;
    branch_compare_pkg::status_type  flags_d;
    branch_compare_pkg::status_type  pend_flags_q;
    branch_compare_pkg::state_type   state_q;
    branch_compare_pkg::result_type  result_view;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [15:0] pend_pc_q;
    logic [15:0] offset_ext;
    logic [1:0]  cnt_q;
    logic [1:0]  cycles_d;
    logic [1:0]  cycles_q;
    logic [8:0]  diff;
    logic [7:0]  res;
    logic [7:0]  flag_vec;
    logic [7:0]  cmp_b;
    logic        borrow;
    logic        is_cmp;
    logic        is_skip;
    logic        is_branch;
    logic        take_d;
    logic        bad_d;
    logic        taken_q;
    logic        bad_q;
    logic        done_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic        mapped;
    logic        wr_en;
    logic        launch;

    // Bus strobes; access phase completes on the registered ready
    assign wr_en  = psel && penable && pwrite && pready_q;
    assign launch = wr_en && (paddr == branch_compare_pkg::CTRL_OFFSET)
                    && pwdata[branch_compare_pkg::START_BIT]
                    && (state_q == branch_compare_pkg::ST_IDLE);

    // Address decode for reads and for the error answer
    always_comb begin
        result_view        = '0;
        result_view.pc     = pc_q;
        result_view.busy   = (state_q == branch_compare_pkg::ST_EXEC);
        result_view.taken  = taken_q;
        result_view.bad_op = bad_q;
        result_view.cycles = cycles_q;
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == branch_compare_pkg::CTRL_OFFSET) begin
            rd_mux = 32'h0000_0000;
        end else if (paddr == branch_compare_pkg::OPCODE_OFFSET) begin
            rd_mux = {23'h00_0000, op_q};
        end else if (paddr == branch_compare_pkg::OPERAND_OFFSET) begin
            rd_mux = {9'h000, operand_q};
        end else if (paddr == branch_compare_pkg::PC_OFFSET) begin
            rd_mux = {16'h0000, pc_q};
        end else if (paddr == branch_compare_pkg::FLAGS_OFFSET) begin
            rd_mux = {24'h00_0000, flags_q};
        end else if (paddr == branch_compare_pkg::RESULT_OFFSET) begin
            rd_mux = result_view;
        end else begin
            mapped = 1'b0;
        end
    end

    // APB answer: one wait-free access phase, data latched at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // Instruction registers; writes while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q      <= '0;
            operand_q <= '0;
        end else if (wr_en && state_q == branch_compare_pkg::ST_IDLE) begin
            if (paddr == branch_compare_pkg::OPCODE_OFFSET) begin
                op_q <= pwdata[$bits(op_q)-1:0];
            end else if (paddr == branch_compare_pkg::OPERAND_OFFSET) begin
                operand_q <= pwdata[$bits(operand_q)-1:0];
            end
        end
    end

    // Subtraction shared by the three flag-setting compares
    always_comb begin
        is_cmp = (op_q.op == branch_compare_pkg::OP_REGISTER_COMPARE)
              || (op_q.op == branch_compare_pkg::OP_COMPARE_WITH_BORROW)
              || (op_q.op == branch_compare_pkg::OP_IMMEDIATE_COMPARE);
        cmp_b  = operand_q.rr_val;
        borrow = (op_q.op == branch_compare_pkg::OP_COMPARE_WITH_BORROW)
                 && flags_q.c;
        diff   = {1'b0, operand_q.rd_val} - {1'b0, cmp_b}
                 - {8'h00, borrow};
        res    = diff[7:0];
        flags_d = flags_q;
        if (is_cmp) begin
            // With a carry in, Z survives only if it was already set
            flags_d.z = (res == 8'h00) && (!borrow || flags_q.z);
            if (op_q.op != branch_compare_pkg::OP_COMPARE_WITH_BORROW) begin
                flags_d.z = (res == 8'h00);
            end
            flags_d.n = res[7];
            flags_d.v = (operand_q.rd_val[7] && !cmp_b[7] && !res[7])
                     || (!operand_q.rd_val[7] && cmp_b[7] && res[7]);
            flags_d.c = (!operand_q.rd_val[7] && cmp_b[7])
                     || (cmp_b[7] && res[7])
                     || (res[7] && !operand_q.rd_val[7]);
            flags_d.h = (!operand_q.rd_val[3] && cmp_b[3])
                     || (cmp_b[3] && res[3])
                     || (res[3] && !operand_q.rd_val[3]);
            flags_d.s = flags_d.n ^ flags_d.v;
        end
    end

    // Condition, target and cycle count of the staged instruction
    always_comb begin
        flag_vec   = flags_q;
        offset_ext = {{9{operand_q.offset[6]}}, operand_q.offset};
        is_skip    = 1'b0;
        is_branch  = 1'b0;
        take_d     = 1'b0;
        bad_d      = 1'b0;
        case (op_q.op)
            branch_compare_pkg::OP_EQUAL_SKIP_COMPARE: begin
                is_skip = 1'b1;
                take_d  = (operand_q.rd_val == operand_q.rr_val);
            end
            branch_compare_pkg::OP_REGISTER_COMPARE,
            branch_compare_pkg::OP_COMPARE_WITH_BORROW,
            branch_compare_pkg::OP_IMMEDIATE_COMPARE: begin
                take_d = 1'b0;
            end
            branch_compare_pkg::OP_SKIP_ON_REG_BIT_LOW: begin
                is_skip = 1'b1;
                take_d  = !operand_q.rd_val[op_q.bit_idx];
            end
            branch_compare_pkg::OP_SKIP_ON_REG_BIT_HIGH: begin
                is_skip = 1'b1;
                take_d  = operand_q.rd_val[op_q.bit_idx];
            end
            // The I/O register content is staged in the second operand
            branch_compare_pkg::OP_SKIP_ON_IO_BIT_LOW: begin
                is_skip = 1'b1;
                take_d  = !operand_q.rr_val[op_q.bit_idx];
            end
            branch_compare_pkg::OP_SKIP_ON_IO_BIT_HIGH: begin
                is_skip = 1'b1;
                take_d  = operand_q.rr_val[op_q.bit_idx];
            end
            branch_compare_pkg::OP_BRANCH_FLAG_SET: begin
                is_branch = 1'b1;
                take_d    = flag_vec[op_q.bit_idx];
            end
            branch_compare_pkg::OP_BRANCH_FLAG_CLEAR: begin
                is_branch = 1'b1;
                take_d    = !flag_vec[op_q.bit_idx];
            end
            branch_compare_pkg::OP_BRANCH_EQUAL: begin
                is_branch = 1'b1;
                take_d    = flags_q.z;
            end
            branch_compare_pkg::OP_BRANCH_NOT_EQUAL: begin
                is_branch = 1'b1;
                take_d    = !flags_q.z;
            end
            branch_compare_pkg::OP_BRANCH_CARRY_LOW,
            branch_compare_pkg::OP_BRANCH_SAME_OR_HIGHER: begin
                is_branch = 1'b1;
                take_d    = !flags_q.c;
            end
            branch_compare_pkg::OP_BRANCH_CARRY_HIGH,
            branch_compare_pkg::OP_BRANCH_UNSIGNED_LOWER: begin
                is_branch = 1'b1;
                take_d    = flags_q.c;
            end
            branch_compare_pkg::OP_BRANCH_MINUS: begin
                is_branch = 1'b1;
                take_d    = flags_q.n;
            end
            branch_compare_pkg::OP_BRANCH_PLUS: begin
                is_branch = 1'b1;
                take_d    = !flags_q.n;
            end
            branch_compare_pkg::OP_BRANCH_SIGNED_GE: begin
                is_branch = 1'b1;
                take_d    = !(flags_q.n ^ flags_q.v);
            end
            branch_compare_pkg::OP_BRANCH_SIGNED_LESS: begin
                is_branch = 1'b1;
                take_d    = flags_q.n ^ flags_q.v;
            end
            branch_compare_pkg::OP_BRANCH_HALF_CARRY_SET: begin
                is_branch = 1'b1;
                take_d    = flags_q.h;
            end
            branch_compare_pkg::OP_BRANCH_HALF_CARRY_CLEAR: begin
                is_branch = 1'b1;
                take_d    = !flags_q.h;
            end
            default: begin
                bad_d = 1'b1;
            end
        endcase
        pc_d     = pc_q + branch_compare_pkg::PC_STEP;
        cycles_d = branch_compare_pkg::CYC_PLAIN;
        if (take_d && is_branch) begin
            pc_d     = pc_q + offset_ext + branch_compare_pkg::PC_STEP;
            cycles_d = branch_compare_pkg::CYC_JUMP;
        end else if (take_d && is_skip && op_q.two_word) begin
            pc_d     = pc_q + branch_compare_pkg::SKIP_TWO;
            cycles_d = branch_compare_pkg::CYC_SKIP_TWO;
        end else if (take_d && is_skip) begin
            pc_d     = pc_q + branch_compare_pkg::SKIP_ONE;
            cycles_d = branch_compare_pkg::CYC_JUMP;
        end
    end

    // Sequencer: holds the outcome until its last cycle has passed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= branch_compare_pkg::ST_IDLE;
            cnt_q        <= 2'h0;
            cycles_q     <= 2'h0;
            pend_pc_q    <= branch_compare_pkg::PC_RESET;
            pend_flags_q <= branch_compare_pkg::FLAGS_RESET;
            taken_q      <= 1'b0;
            bad_q        <= 1'b0;
            done_q       <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                branch_compare_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_q      <= branch_compare_pkg::ST_EXEC;
                        cnt_q        <= cycles_d;
                        cycles_q     <= cycles_d;
                        pend_pc_q    <= pc_d;
                        pend_flags_q <= flags_d;
                        taken_q      <= take_d;
                        bad_q        <= bad_d;
                    end
                end
                branch_compare_pkg::ST_EXEC: begin
                    if (cnt_q == branch_compare_pkg::CYC_PLAIN) begin
                        state_q <= branch_compare_pkg::ST_IDLE;
                        done_q  <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                default: begin
                    state_q <= branch_compare_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // PC and flags: software loads them only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q    <= branch_compare_pkg::PC_RESET;
            flags_q <= branch_compare_pkg::FLAGS_RESET;
        end else if (state_q == branch_compare_pkg::ST_EXEC
                     && cnt_q == branch_compare_pkg::CYC_PLAIN) begin
            pc_q    <= pend_pc_q;
            flags_q <= pend_flags_q;
        end else if (wr_en && state_q == branch_compare_pkg::ST_IDLE) begin
            if (paddr == branch_compare_pkg::PC_OFFSET) begin
                pc_q <= pwdata[15:0];
            end else if (paddr == branch_compare_pkg::FLAGS_OFFSET) begin
                flags_q <= pwdata[7:0];
            end
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign pc_out    = pc_q;
    assign flags_out = flags_q;
    assign busy      = (state_q == branch_compare_pkg::ST_EXEC);
    assign done      = done_q;

    // Checks: outcome lands one edge after its last cycle
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_done_in_one;
        ##2 done_q;
    endsequence

    sequence s_done_in_two;
        ##1 busy ##2 done_q;
    endsequence

    a_cmp_one_cycle: assert property (
        launch && is_cmp |-> s_done_in_one)
        else $error("compare did not finish in one cycle");

    a_cmp_zero_flag: assert property (
        launch && op_q.op == branch_compare_pkg::OP_REGISTER_COMPARE
        |-> ##2 flags_q.z == (operand_q.rd_val == operand_q.rr_val))
        else $error("compare zero flag wrong");

    a_equal_skip_pc: assert property (
        launch && op_q.op == branch_compare_pkg::OP_EQUAL_SKIP_COMPARE
        && take_d && !op_q.two_word
        |-> s_done_in_two ##0 pc_q == $past(pc_q, 3) + 16'h0002)
        else $error("equal skip did not advance by two");

    a_two_word_skip: assert property (
        launch && is_skip && take_d && op_q.two_word
        |-> ##4 done_q && pc_q == $past(pc_q, 4) + 16'h0003)
        else $error("two-word skip wrong");

    a_reg_bit_low: assert property (
        launch && op_q.op == branch_compare_pkg::OP_SKIP_ON_REG_BIT_LOW
        && operand_q.rd_val[op_q.bit_idx]
        |-> ##2 done_q && pc_q == $past(pc_q, 2) + 16'h0001)
        else $error("register bit low skip took a wrong path");

    a_io_bit_high: assert property (
        launch && op_q.op == branch_compare_pkg::OP_SKIP_ON_IO_BIT_HIGH
        && !operand_q.rr_val[op_q.bit_idx] |-> s_done_in_one)
        else $error("io bit high no-skip not one cycle");

    a_branch_taken: assert property (
        launch && is_branch && take_d
        |-> ##3 done_q && pc_q == $past(pc_q, 3) + $past(offset_ext, 3)
            + 16'h0001)
        else $error("taken branch target or timing wrong");

    a_branch_flags: assert property (
        launch && is_branch |-> ##1 $stable(flags_q) [*2])
        else $error("branch altered the flags");

    a_signed_less: assert property (
        launch && op_q.op == branch_compare_pkg::OP_BRANCH_SIGNED_LESS
        && !(flags_q.n ^ flags_q.v) |-> ##2 done_q)
        else $error("signed less branch taken wrongly");

endmodule

`default_nettype wire

// [src/branch_compare_pkg.sv]
// Constants, types and register map of the branch, compare and skip unit
package branch_compare_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] OPCODE_OFFSET  = 8'h04;
    localparam logic [7:0] OPERAND_OFFSET = 8'h08;
    localparam logic [7:0] PC_OFFSET      = 8'h0C;
    localparam logic [7:0] FLAGS_OFFSET   = 8'h10;
    localparam logic [7:0] RESULT_OFFSET  = 8'h14;

    // Field positions, reset values and PC increments
    localparam int          START_BIT   = 0;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_STEP     = 16'h0001;
    localparam logic [15:0] SKIP_ONE    = 16'h0002;
    localparam logic [15:0] SKIP_TWO    = 16'h0003;

    // Cycle counts per outcome
    localparam logic [1:0] CYC_PLAIN    = 2'h1;
    localparam logic [1:0] CYC_JUMP     = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;

    // Instruction selector
    typedef enum logic [4:0] {
        OP_EQUAL_SKIP_COMPARE      = 5'h00,
        OP_REGISTER_COMPARE        = 5'h01,
        OP_COMPARE_WITH_BORROW     = 5'h02,
        OP_IMMEDIATE_COMPARE       = 5'h03,
        OP_SKIP_ON_REG_BIT_LOW     = 5'h04,
        OP_SKIP_ON_REG_BIT_HIGH    = 5'h05,
        OP_SKIP_ON_IO_BIT_LOW      = 5'h06,
        OP_SKIP_ON_IO_BIT_HIGH     = 5'h07,
        OP_BRANCH_FLAG_SET         = 5'h08,
        OP_BRANCH_FLAG_CLEAR       = 5'h09,
        OP_BRANCH_EQUAL            = 5'h0A,
        OP_BRANCH_NOT_EQUAL        = 5'h0B,
        OP_BRANCH_CARRY_HIGH       = 5'h0C,
        OP_BRANCH_CARRY_LOW        = 5'h0D,
        OP_BRANCH_SAME_OR_HIGHER   = 5'h0E,
        OP_BRANCH_UNSIGNED_LOWER   = 5'h0F,
        OP_BRANCH_MINUS            = 5'h10,
        OP_BRANCH_PLUS             = 5'h11,
        OP_BRANCH_SIGNED_GE        = 5'h12,
        OP_BRANCH_SIGNED_LESS      = 5'h13,
        OP_BRANCH_HALF_CARRY_SET   = 5'h14,
        OP_BRANCH_HALF_CARRY_CLEAR = 5'h15
    } op_type;

    // Status flags register, bit 0 is carry
    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } status_type;

    // Opcode register layout, low bits of the word
    typedef struct packed {
        logic       two_word;
        logic [2:0] bit_idx;
        op_type     op;
    } op_word_type;

    // Operand register layout, low bits of the word
    typedef struct packed {
        logic [6:0] offset;
        logic [7:0] rr_val;
        logic [7:0] rd_val;
    } operand_type;

    // Result register layout
    typedef struct packed {
        logic [10:0] pad;
        logic [1:0]  cycles;
        logic        bad_op;
        logic        taken;
        logic        busy;
        logic [15:0] pc;
    } result_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } state_type;

endpackage

// [dv/tb.sv]
// Self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic                           pclk;
    logic                           presetn;
    logic [7:0]                     paddr;
    logic                           psel;
    logic                           penable;
    logic                           pwrite;
    logic [31:0]                    pwdata;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    logic [15:0]                    pc_out;
    branch_compare_pkg::status_type flags_out;
    logic                           busy;
    logic                           done;
    int                             n_fail;
    int                             n_compared;
    int                             seed;

    branch_compare_skip_unit uut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pc_out(pc_out), .flags_out(flags_out),
        .busy(busy), .done(done));

    // Free-running core clock
    always #5 pclk = ~pclk;

    task automatic close_out();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // One APB transfer; a lost pready ends the run
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            n_fail++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    // Reference outcome of one instruction
    function automatic void model(input logic [4:0] op, input logic [2:0] b,
        input logic two, input logic [7:0] rd, input logic [7:0] rr,
        input logic [6:0] k, input logic [15:0] pc, input logic [7:0] fi,
        output logic [15:0] po, output logic [7:0] fo,
        output logic [1:0] cy, output logic tk, output logic bad);
        logic [8:0] df;
        logic [4:0] hf;
        logic       cin;
        logic       br;
        fo  = fi;
        tk  = 1'b0;
        bad = 1'b0;
        br  = (op >= 5'h08 && op <= 5'h15);
        cin = (op == 5'h02) ? fi[0] : 1'b0;
        df  = {1'b0, rd} - {1'b0, rr} - {8'h00, cin};
        hf  = {1'b0, rd[3:0]} - {1'b0, rr[3:0]} - {4'h0, cin};
        case (op)
            5'h00: tk = (rd == rr);
            5'h01, 5'h02, 5'h03: begin
                fo[0] = df[8];
                fo[5] = hf[4];
                fo[1] = (df[7:0] == 8'h00) && (op != 5'h02 || !cin || fi[1]);
                fo[2] = df[7];
                fo[3] = (rd[7] & ~rr[7] & ~df[7]) | (~rd[7] & rr[7] & df[7]);
                fo[4] = fo[2] ^ fo[3];
            end
            // Register bit skips test Rd, I/O bit skips the staged Rr
            5'h04: tk = ~rd[b];
            5'h05: tk = rd[b];
            5'h06: tk = ~rr[b];
            5'h07: tk = rr[b];
            5'h08: tk = fi[b];
            5'h09: tk = ~fi[b];
            5'h0A: tk = fi[1];
            5'h0B: tk = ~fi[1];
            5'h0C, 5'h0F: tk = fi[0];
            5'h0D, 5'h0E: tk = ~fi[0];
            5'h10: tk = fi[2];
            5'h11: tk = ~fi[2];
            5'h12: tk = ~(fi[2] ^ fi[3]);
            5'h13: tk = fi[2] ^ fi[3];
            5'h14: tk = fi[5];
            5'h15: tk = ~fi[5];
            default: bad = 1'b1;
        endcase
        if (br && tk) begin
            po = pc + {{9{k[6]}}, k} + 16'h0001;
            cy = 2'h2;
        end else if (tk) begin
            po = pc + (two ? 16'h0003 : 16'h0002);
            cy = two ? 2'h3 : 2'h2;
        end else begin
            po = pc + 16'h0001;
            cy = 2'h1;
        end
    endfunction

    // Load operands, launch, time the run and check the outcome
    task automatic run(input logic [4:0] op, input logic [2:0] b,
        input logic two, input logic [7:0] rd, input logic [7:0] rr,
        input logic [6:0] k, input logic [15:0] pc, input logic [7:0] fl,
        input logic poke);
        logic [15:0] po;
        logic [7:0]  fo;
        logic [1:0]  cy;
        logic        tk;
        logic        bad;
        logic [31:0] r;
        logic        e;
        int          cnt;
        model(op, b, two, rd, rr, k, pc, fl, po, fo, cy, tk, bad);
        wr(branch_compare_pkg::PC_OFFSET, {16'h0000, pc});
        wr(branch_compare_pkg::FLAGS_OFFSET, {24'h000000, fl});
        wr(branch_compare_pkg::OPCODE_OFFSET, {23'h000000, two, b, op});
        wr(branch_compare_pkg::OPERAND_OFFSET, {9'h000, k, rr, rd});
        wr(branch_compare_pkg::CTRL_OFFSET, 32'h00000001);
        cnt = 0;
        if (poke) begin
            wr(branch_compare_pkg::PC_OFFSET, 32'h0000ABCD);
            cnt = 3;
        end
        // Look just after the edge, so a done raised by the poke's last
        // edge is not missed
        #1;
        if (!poke) begin
            chk("busy at launch", 32'h1, {31'h0, busy});
        end
        while (done !== 1'b1 && cnt < 20) begin
            @(posedge pclk);
            cnt++;
            #1;
        end
        chk("edges to done", {30'h0, cy}, cnt);
        chk("busy at done", 32'h0, {31'h0, busy});
        chk("pc_out", {16'h0000, po}, {16'h0000, pc_out});
        chk("flags_out", {24'h0, fo}, {24'h0, flags_out});
        apb(branch_compare_pkg::RESULT_OFFSET, 1'b0, 32'h0, r, e);
        chk("result", {11'h000, cy, bad, tk, 1'b0, po}, r);
    endtask

    initial begin
        logic [31:0] r;
        logic [31:0] q;
        logic        e;
        pclk = 1'b0;
        presetn = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h00000000;
        n_fail = 0;
        n_compared = 0;
        seed = 43;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(branch_compare_pkg::RESULT_OFFSET, 1'b0, 32'h0, r, e);
        chk("result after reset", 32'h00000000, r);
        // Unmapped word answers with an error and reads zero
        apb(8'h18, 1'b0, 32'h0, r, e);
        chk("unmapped data", 32'h00000000, r);
        chk("unmapped error", 32'h00000001, {31'h0, e});
        // Every selector, corners first: equal operands and one poke
        for (int op = 0; op < 23; op++) begin
            for (int rep = 0; rep < 4; rep++) begin
                r = $random(seed);
                q = $random(seed);
                run(op[4:0], r[25:23], rep[0], (rep < 2) ? r[7:0] : r[15:8],
                    r[7:0], r[22:16], q[15:0], q[23:16],
                    (op == 0 && rep == 1));
            end
        end
        // Second reset while the unit is idle clears the core state
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk("pc after reset", 32'h0, {16'h0000, pc_out});
        chk("flags after reset", 32'h0, {24'h0, flags_out});
        presetn <= 1'b1;
        apb(branch_compare_pkg::RESULT_OFFSET, 1'b0, 32'h0, r, e);
        chk("result after second reset", 32'h00000000, r);
        close_out();
    end
endmodule

`default_nettype wire
